// ---- verilog/pic_map.vh ----
// Register map, field positions, reset values and vector layout of the
// prioritized interrupt controller. Assumes word-addressed AHB-Lite decode.
`ifndef PIC_MAP_VH
`define PIC_MAP_VH

// Printed register offsets (indices); byte address is four times the index
`define PIC_IDX_G0_EN_HIGH 12'hFC1
`define PIC_IDX_G0_EN_LOW 12'hFC2
`define PIC_IDX_G1_EN_HIGH 12'hFC3
`define PIC_IDX_G1_EN_LOW 12'hFC4
`define PIC_IDX_G2_EN_HIGH 12'hFC5
`define PIC_IDX_G2_EN_LOW 12'hFC6
`define PIC_IDX_REQ0 12'hFC7
`define PIC_IDX_REQ1 12'hFC8
`define PIC_IDX_REQ2 12'hFC9
`define PIC_IDX_EDGE_SEL 12'hFCA
`define PIC_IDX_CTRL 12'hFCB
`define PIC_IDX_STATUS 12'hFCC

// Group 0 field positions
`define PIC_G0_TIMER1_BIT 6
`define PIC_G0_TIMER0_BIT 5
`define PIC_G0_SERIAL_RX_BIT 4
`define PIC_G0_SERIAL_TX_BIT 3
`define PIC_G0_WDOG_BIT 1
`define PIC_G0_CONV_BIT 0
// Writable bits of group 0 enable pair; bits 7,2,1 read zero
`define PIC_G0_EN_MASK 8'h79
// Group 2 holds the four dual-edge pins in its low nibble
`define PIC_G2_EN_MASK 8'h0F

// Reset values
`define PIC_EN_RESET 8'h00
`define PIC_CTRL_RESET 8'h00

// Control register fields
`define PIC_CTRL_VEC_EN_BIT 0

// Priority encodings
`define PIC_PRI_OFF 2'h0
`define PIC_PRI_HIGH 2'h3

// Vector table
`define PIC_NUM_SRC 20
`define PIC_VEC_BASE 16'h0002

`endif

// ---- verilog/pic_edge_det.v ----
// One pin edge detector for the interrupt controller.
// Assumes the pin is asynchronous; it is synchronised here before use.
`timescale 1ns/10ps
`default_nettype none

module pic_edge_det (
  input wire core_clk,
  input wire sys_rst,
  input wire pin_in,
  input wire dual_edge,
  input wire fall_sel,
  output reg edge_pulse
);

  reg sync1_reg; // First synchroniser stage, read only by the second
  reg sync2_reg; // Second synchroniser stage
  reg last_reg; // Previous synchronised level
  wire rise_w;
  wire fall_w;

  assign rise_w = sync2_reg & ~last_reg;
  assign fall_w = ~sync2_reg & last_reg;

  // Synchronise and detect the chosen edge as a one-cycle pulse
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
      if (dual_edge) begin
        edge_pulse <= rise_w | fall_w;
      end else if (fall_sel) begin
        edge_pulse <= fall_w;
      end else begin
        edge_pulse <= rise_w;
      end
    end
  end

endmodule

`default_nettype wire

// ---- verilog/pic_ctrl.v ----
// Prioritized interrupt controller: AHB-Lite register slave, request
// latching, three-level arbitration and vector fetch for the core.
// Assumes peripheral requests are one-cycle pulses on core_clk and pins
// are asynchronous; the core acknowledges the vector it was offered.
// Absent sources are modelled by gating requests; the map stays fixed.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pic_map.vh"

module pic_ctrl #(
  parameter HAS_CONVERTER = 1,
  parameter [11:0] PIN_PRESENT = 12'hFFF
) (
  input wire core_clk,
  input wire sys_rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire [7:0] periph_req,
  input wire [11:0] gpio_pin,
  output reg irq_to_core,
  output reg [4:0] irq_vector_id,
  input wire irq_ack,
  output reg [15:0] vec_fetch_addr,
  output reg vec_fetch_req,
  input wire [7:0] vec_fetch_data,
  input wire vec_fetch_ack,
  output reg [15:0] isr_addr,
  output reg isr_valid
);

  // Enable pairs: group0 peripherals, group1 pins 0-7, group2 pins 8-11
  // All of them reset to zero, so every source starts disabled
  reg [7:0] g0_high_reg;
  reg [7:0] g0_low_reg;
  reg [7:0] g1_high_reg;
  reg [7:0] g1_low_reg;
  reg [7:0] g2_high_reg;
  reg [7:0] g2_low_reg;
  reg [7:0] edge_sel_reg; // Falling-edge select for group1 pins
  reg [7:0] ctrl_reg; // Bit 0 enables vectoring
  reg [19:0] pend_reg; // Sticky request flags
  // Bus data phase state
  // A write is remembered from its address phase to its data phase
  reg wr_pend_reg; // Write data arrives this cycle
  reg [11:0] wr_idx_reg;
  reg [31:0] rdata_reg;
  // Vector fetch state machine
  // Binary codes, all four used; the default branch falls back to idle
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_MSB = 2'b01;
  localparam [1:0] ST_LSB = 2'b10;
  localparam [1:0] ST_DONE = 2'b11;
  // state_next is combinational; state_reg moves only on the clock
  reg [1:0] state_reg; // Current fetch step
  reg [1:0] state_next; // Step for the next edge
  reg [4:0] win_reg; // Source being serviced
  reg [7:0] vec_msb_reg;

  // Combinational request, priority and decode nets
  wire [11:0] pin_edge; // One-cycle pulses from the pin detectors
  wire [19:0] raw_req; // Requests arriving this cycle
  wire [19:0] clr_req; // Flag cleared by the core's acknowledge
  wire [39:0] pri_all; // Two priority bits per source
  wire addr_ok; // Address phase hits the register window
  wire [11:0] a_idx; // Register index from the byte address
  wire vec_en; // Vectored mode; low means software polls

  // Pin edge detectors: eight selectable, four dual-edge
  // Pins 8-11 ignore the select register and always see both edges
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi = gi + 1) begin : g_pin
      pic_edge_det u_det (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pin_in(gpio_pin[gi]),
        .dual_edge(gi >= 8 ? 1'b1 : 1'b0),
        .fall_sel(gi < 8 ? edge_sel_reg[gi % 8] : 1'b0),
        .edge_pulse(pin_edge[gi])
      );
    end
  endgenerate

  // Source order: 0-7 peripherals (group0 bit order), 8-19 pins
  // Watchdog request arrives on periph_req[1] and shares that slot
  // Absent sources are gated here; their enable bits can still be written,
  // but no flag ever sets for them, so they can never win
  assign raw_req[7:0] = periph_req &
    {7'h7F, (HAS_CONVERTER != 0) ? 1'b1 : 1'b0};
  assign raw_req[19:8] = pin_edge & PIN_PRESENT;

  // Per source two-bit priority from the concatenated enable pair
  // Group2 has only four pins; its upper pair bits are masked on write
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pri01
      assign pri_all[2*gi+1:2*gi] = {g0_high_reg[gi], g0_low_reg[gi]};
      assign pri_all[2*(gi+8)+1:2*(gi+8)] = {g1_high_reg[gi], g1_low_reg[gi]};
    end
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pri2
      assign pri_all[2*(gi+16)+1:2*(gi+16)] = {g2_high_reg[gi], g2_low_reg[gi]};
    end
  endgenerate

  // With vectoring off the core polls the flags and no new vector fetch is started;
  // flags still set, and software clears them by writing ones
  assign vec_en = ctrl_reg[`PIC_CTRL_VEC_EN_BIT];

  // Arbiter: highest level, lowest index on tie; level 00 masked
  // Level 00 is below any real level, so a masked flag never wins.
  // The twenty compares form the longest path, kept combinational so a
  // winner is known the cycle after its flag sets.
  // Fixed tie order lets a busy early source starve a later one.
  reg [1:0] best_pri;
  reg [4:0] best_id;
  reg best_any;
  integer k;
  always @* begin
    best_pri = `PIC_PRI_OFF;
    best_id = 5'h00;
    best_any = 1'b0;
    for (k = 0; k < `PIC_NUM_SRC; k = k + 1) begin
      // Strict greater-than keeps the earliest vector on a tie
      if (pend_reg[k] && pri_all[2*k +: 2] > best_pri) begin
        best_pri = pri_all[2*k +: 2];
        best_id = k[4:0];
        best_any = 1'b1;
      end
    end
  end

  // Clear the serviced flag when the core acknowledges
  // Only the source that was offered is cleared; others stay pending.
  // An acknowledge with no offer outstanding clears nothing.
  assign clr_req = (irq_ack && irq_to_core) ? (20'h00001 << win_reg) : 20'h00000;

  // Software may also clear flags by writing ones to request registers
  // The clear lines up with the data phase, when hwdata is valid
  wire [19:0] sw_clr;
  assign sw_clr = !wr_pend_reg ? 20'h00000 :
    (wr_idx_reg == `PIC_IDX_REQ0) ? {12'h000, hwdata[7:0]} :
    (wr_idx_reg == `PIC_IDX_REQ1) ? {4'h0, hwdata[7:0], 8'h00} :
    (wr_idx_reg == `PIC_IDX_REQ2) ? {hwdata[3:0], 16'h0000} : 20'h00000;

  // Pending flags: a new request wins over a same-cycle clear,
  // so a request that lands on its own acknowledge is served again
  always @(posedge core_clk) begin
    if (sys_rst) begin
      pend_reg <= 20'h00000;
    end else begin
      pend_reg <= (pend_reg & ~(clr_req | sw_clr)) | raw_req;
    end
  end

  // Bus address phase decode
  // Upper address bits are not decoded, so the map repeats every 16 KB;
  // the slave never stalls, so ready and response are constants
  assign a_idx = haddr[13:2];
  assign addr_ok = (a_idx >= `PIC_IDX_G0_EN_HIGH) && (a_idx <= `PIC_IDX_STATUS);
  assign hreadyout = 1'b1; // Zero wait states
  assign hresp = 1'b0; // Always OKAY
  assign hrdata = rdata_reg;

  // Register read multiplexer
  // Read data is taken in the address phase and held for the data phase;
  // status shows the current winner even while vectoring is off
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (a_idx)
      `PIC_IDX_G0_EN_HIGH: rd_mux[7:0] = g0_high_reg;
      `PIC_IDX_G0_EN_LOW: rd_mux[7:0] = g0_low_reg;
      `PIC_IDX_G1_EN_HIGH: rd_mux[7:0] = g1_high_reg;
      `PIC_IDX_G1_EN_LOW: rd_mux[7:0] = g1_low_reg;
      `PIC_IDX_G2_EN_HIGH: rd_mux[7:0] = g2_high_reg;
      `PIC_IDX_G2_EN_LOW: rd_mux[7:0] = g2_low_reg;
      `PIC_IDX_REQ0: rd_mux[7:0] = pend_reg[7:0];
      `PIC_IDX_REQ1: rd_mux[7:0] = pend_reg[15:8];
      `PIC_IDX_REQ2: rd_mux[3:0] = pend_reg[19:16];
      `PIC_IDX_EDGE_SEL: rd_mux[7:0] = edge_sel_reg;
      `PIC_IDX_CTRL: rd_mux[7:0] = ctrl_reg;
      `PIC_IDX_STATUS: rd_mux[7:0] = {best_any, 2'b00, best_id};
      default: rd_mux = 32'h00000000; // Unmapped reads as zero
    endcase
  end

  // Bus slave: capture write address, return read data next edge
  // Writes are only remembered here and land one edge later
  always @(posedge core_clk) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 12'h000;
      rdata_reg <= 32'h00000000;
    end else begin
      wr_pend_reg <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        wr_pend_reg <= hwrite && addr_ok;
        wr_idx_reg <= a_idx;
        if (!hwrite) begin
          rdata_reg <= rd_mux;
        end
      end
    end
  end

  // Register writes in the data phase; reserved bits forced to zero
  // Masking on the way in keeps reserved positions reading zero
  always @(posedge core_clk) begin
    if (sys_rst) begin
      g0_high_reg <= `PIC_EN_RESET;
      g0_low_reg <= `PIC_EN_RESET;
      g1_high_reg <= `PIC_EN_RESET;
      g1_low_reg <= `PIC_EN_RESET;
      g2_high_reg <= `PIC_EN_RESET;
      g2_low_reg <= `PIC_EN_RESET;
      edge_sel_reg <= 8'h00;
      ctrl_reg <= `PIC_CTRL_RESET;
    end else if (wr_pend_reg) begin
      case (wr_idx_reg)
        `PIC_IDX_G0_EN_HIGH: g0_high_reg <= hwdata[7:0] & `PIC_G0_EN_MASK;
        `PIC_IDX_G0_EN_LOW: g0_low_reg <= hwdata[7:0] & `PIC_G0_EN_MASK;
        `PIC_IDX_G1_EN_HIGH: g1_high_reg <= hwdata[7:0];
        `PIC_IDX_G1_EN_LOW: g1_low_reg <= hwdata[7:0];
        `PIC_IDX_G2_EN_HIGH: g2_high_reg <= hwdata[7:0] & `PIC_G2_EN_MASK;
        `PIC_IDX_G2_EN_LOW: g2_low_reg <= hwdata[7:0] & `PIC_G2_EN_MASK;
        `PIC_IDX_EDGE_SEL: edge_sel_reg <= hwdata[7:0];
        `PIC_IDX_CTRL: ctrl_reg <= {7'h00, hwdata[0]};
        // Flag, status and unmapped indices leave these registers as they were
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Vector fetch sequence next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // Start a fetch as soon as an enabled flag wins
        if (best_any && vec_en) begin
          state_next = ST_MSB;
        end
      end
      ST_MSB: begin
        // Wait for the even byte
        if (vec_fetch_ack) begin
          state_next = ST_LSB;
        end
      end
      ST_LSB: begin
        // Wait for the odd byte
        if (vec_fetch_ack) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        // Hold the vector until the core takes it or polling resumes
        if (irq_ack || !vec_en) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Vector fetch datapath: MSB at even, LSB at following odd address
  // Once started, a fetch runs to its end even if vectoring is switched off
  always @(posedge core_clk) begin
    if (sys_rst) begin
      // Everything comes up idle; nothing is offered before software acts
      state_reg <= ST_IDLE;
      win_reg <= 5'h00;
      vec_msb_reg <= 8'h00;
      vec_fetch_addr <= 16'h0000;
      vec_fetch_req <= 1'b0;
      isr_addr <= 16'h0000;
      isr_valid <= 1'b0;
      irq_to_core <= 1'b0;
      irq_vector_id <= 5'h00;
    end else begin
      state_reg <= state_next;
      case (state_reg)
        ST_IDLE: begin
          irq_to_core <= 1'b0;
          isr_valid <= 1'b0;
          if (best_any && vec_en) begin
            // Latch the winner so later flags cannot change the vector
            win_reg <= best_id;
            vec_fetch_addr <= `PIC_VEC_BASE + {10'h000, best_id, 1'b0};
            vec_fetch_req <= 1'b1;
          end
        end
        ST_MSB: begin
          if (vec_fetch_ack) begin
            // Keep the high byte and step to the odd address
            vec_msb_reg <= vec_fetch_data;
            vec_fetch_addr <= vec_fetch_addr | 16'h0001;
          end
        end
        ST_LSB: begin
          if (vec_fetch_ack) begin
            // Assemble the vector and offer it to the core
            vec_fetch_req <= 1'b0;
            isr_addr <= {vec_msb_reg, vec_fetch_data};
            isr_valid <= 1'b1;
            irq_to_core <= 1'b1;
            irq_vector_id <= win_reg;
          end
        end
        ST_DONE: begin
          // Withdraw the offer on acknowledge or when polling resumes
          if (irq_ack || !vec_en) begin
            irq_to_core <= 1'b0;
            isr_valid <= 1'b0;
          end
        end
        default: vec_fetch_req <= 1'b0;
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- bench/pic_ctrl_properties.sv ----
// Checker for pic_ctrl: vector fetch and core handshake.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module pic_ctrl_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic irq_to_core,
  input wire logic irq_ack,
  input wire logic [15:0] vec_fetch_addr,
  input wire logic vec_fetch_req,
  input wire logic [7:0] vec_fetch_data,
  input wire logic vec_fetch_ack,
  input wire logic [15:0] isr_addr,
  input wire logic isr_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] msb_reg; // High byte the core handed over
  // Keep the even byte so the assembled vector can be checked later
  always @(posedge core_clk) begin
    if (vec_fetch_req && vec_fetch_ack && !vec_fetch_addr[0]) begin
      msb_reg <= vec_fetch_data;
    end
  end
  sequence s_msb_taken;
    vec_fetch_req && vec_fetch_ack && !vec_fetch_addr[0];
  endsequence
  sequence s_lsb_taken;
    vec_fetch_req && vec_fetch_ack && vec_fetch_addr[0];
  endsequence
  a_fetch_starts_even: assert property ($rose(vec_fetch_req) |-> !vec_fetch_addr[0])
    else $error("fetch began at odd address");
  a_fetch_next_odd: assert property (s_msb_taken |=> vec_fetch_req
    && vec_fetch_addr == ($past(vec_fetch_addr) | 16'h0001)) else $error("odd byte not fetched");
  a_isr_low_byte: assert property (s_lsb_taken |=> isr_valid
    && isr_addr[7:0] == $past(vec_fetch_data)) else $error("vector low byte wrong");
  a_isr_high_byte: assert property ($rose(isr_valid) |-> isr_addr[15:8] == msb_reg)
    else $error("vector high byte wrong");
  a_valid_with_irq: assert property (isr_valid == irq_to_core)
    else $error("isr_valid and irq_to_core differ");
  a_ack_releases: assert property (irq_to_core && irq_ack |=> !irq_to_core)
    else $error("irq_to_core held after ack");
  a_reset_clears: assert property ($fell(sys_rst) |-> !irq_to_core && !vec_fetch_req)
    else $error("outputs active after reset");
  a_irq_after_fetch: assert property ($rose(irq_to_core) |-> $past(vec_fetch_ack))
    else $error("irq raised without fetch");
endmodule
bind pic_ctrl pic_ctrl_props u_props (.core_clk(core_clk), .sys_rst(sys_rst),
  .irq_to_core(irq_to_core), .irq_ack(irq_ack), .vec_fetch_addr(vec_fetch_addr),
  .vec_fetch_req(vec_fetch_req), .vec_fetch_data(vec_fetch_data),
  .vec_fetch_ack(vec_fetch_ack), .isr_addr(isr_addr), .isr_valid(isr_valid));
`default_nettype wire

// ---- bench/pic_core_model.sv ----
// Core-side model: fetches vector bytes and acknowledges the interrupt.
// Assumes vec_fetch_req is held until each byte is acknowledged.
`timescale 1ns/10ps
`default_nettype none
module pic_core_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic vec_fetch_req,
  input wire logic [15:0] vec_fetch_addr,
  output logic vec_fetch_ack,
  output logic [7:0] vec_fetch_data,
  input wire logic irq_to_core,
  input wire logic [4:0] irq_vector_id,
  input wire logic [15:0] isr_addr,
  output logic irq_ack,
  output logic [4:0] last_id,
  output logic [15:0] last_isr,
  output int served
);
  int wait_cnt; // Stall cycles spent on the current byte
  // Memory byte: high half at even address, low half at the next odd one
  always @(posedge core_clk) begin
    vec_fetch_ack <= 1'b0;
    irq_ack <= 1'b0;
    vec_fetch_data <= ~vec_fetch_data; // No stale byte outside an ack
    if (sys_rst) begin
      wait_cnt <= 0;
      served <= 0;
      vec_fetch_data <= 8'h00;
    end else if (vec_fetch_req && !vec_fetch_ack) begin
      if (wait_cnt < (slow ? 3 : 0)) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        wait_cnt <= 0;
        vec_fetch_ack <= 1'b1;
        vec_fetch_data <= {vec_fetch_addr[0] ? 3'h2 : 3'h4, vec_fetch_addr[5:1]};
      end
    end else if (irq_to_core && !irq_ack) begin
      irq_ack <= 1'b1;
      last_id <= irq_vector_id;
      last_isr <= isr_addr;
      served <= served + 1;
    end
  end
endmodule
`default_nettype wire

// ---- bench/prioritized_irq_controller_tb_top.sv ----
// Self-checking bench for pic_ctrl over AHB-Lite with a core model.
// Assumes one 250 MHz clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module prioritized_irq_controller_tb_top;
  logic core_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, slow = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, c;
  logic [2:0] hsize = 0;
  logic hreadyout, hresp, irq_to_core, isr_valid, irq_ack, vec_fetch_req, vec_fetch_ack;
  logic [7:0] periph_req = 0, vec_fetch_data;
  logic [11:0] gpio_pin = 0;
  logic [4:0] irq_vector_id, last_id;
  logic [15:0] vec_fetch_addr, isr_addr, last_isr;
  int served, mismatches = 0, checks_done = 0, want = 0;
  pic_ctrl #(.HAS_CONVERTER(1), .PIN_PRESENT(12'hFFF)) uut (.core_clk, .sys_rst, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .periph_req, .gpio_pin, .irq_to_core, .irq_vector_id, .irq_ack,
    .vec_fetch_addr, .vec_fetch_req, .vec_fetch_data, .vec_fetch_ack, .isr_addr, .isr_valid);
  pic_core_model u_core (.core_clk, .sys_rst, .slow, .vec_fetch_req, .vec_fetch_addr,
    .vec_fetch_ack, .vec_fetch_data, .irq_to_core, .irq_vector_id, .isr_addr, .irq_ack,
    .last_id, .last_isr, .served);
  // 4 ns period clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic hung;
    mismatches++;
    give_verdict();
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Every bus phase ends at an edge where hready is seen high
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) hung();
  endtask
  task automatic bus(input logic [11:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {18'h0, idx, 2'h0};
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0);
    chk($sformatf("reg %h", idx), rd, exp);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge core_clk);
    periph_req <= m;
    @(posedge core_clk);
    periph_req <= 8'h00;
  endtask
  // Wait for the core model to finish one more interrupt
  task automatic serve(input logic [4:0] id);
    int n;
    n = 0;
    want++;
    while (served < want && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    if (served < want) hung();
    chk("vector id", {27'h0, last_id}, {27'h0, id});
    chk("isr addr", {16'h0, last_isr}, {16'h0, 8'h81 + id, 8'h41 + id});
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 1; i <= 12; i++) rd_chk(12'hFC0 + i[11:0], 32'h0);
    rd_chk(12'hFD0, 32'h0);
    // Vectoring off: flags set, core left alone
    pulse(8'h43);
    repeat (20) @(posedge core_clk);
    chk("served", served, 0);
    rd_chk(12'hFC7, 32'h43);
    bus(12'hFC7, 1'b1, 32'h43);
    rd_chk(12'hFC7, 32'h0);
    bus(12'hFC2, 1'b1, 32'hFF);
    rd_chk(12'hFC2, 32'h79);
    // Level 3 at index 6 beats level 1 at index 3
    bus(12'hFC2, 1'b1, 32'h48);
    bus(12'hFC1, 1'b1, 32'h40);
    rd_chk(12'hFC1, 32'h40);
    // Polled: status names the level 3 winner, then software clears both flags
    pulse(8'h48);
    rd_chk(12'hFCC, 32'h86);
    bus(12'hFC7, 1'b1, 32'h48);
    bus(12'hFCB, 1'b1, 32'h1);
    slow <= 1'b1;
    pulse(8'h48);
    serve(5'd6);
    serve(5'd3);
    // Equal level: lower index first
    bus(12'hFC2, 1'b1, 32'h0);
    bus(12'hFC1, 1'b1, 32'h30);
    slow <= 1'b0;
    pulse(8'h30);
    serve(5'd4);
    serve(5'd5);
    for (int x = 0; x < 8; x++) begin
      c = 2'(x % 3 + 1);
      bus(12'hFC3, 1'b1, {31'h0, c[1]} << x);
      bus(12'hFC4, 1'b1, {31'h0, c[0]} << x);
      @(posedge core_clk);
      gpio_pin[x] <= 1'b1;
      serve(5'd8 + 5'(x));
    end
    bus(12'hFCA, 1'b1, 32'h80);
    @(posedge core_clk);
    gpio_pin[7] <= 1'b0;
    serve(5'd15);
    bus(12'hFC5, 1'b1, 32'h0F);
    bus(12'hFC6, 1'b1, 32'h0F);
    for (int p = 8; p < 12; p++) begin
      @(posedge core_clk);
      gpio_pin[p] <= 1'b1;
      serve(5'd8 + 5'(p));
      @(posedge core_clk);
      gpio_pin[p] <= 1'b0;
      serve(5'd8 + 5'(p));
    end
    give_verdict();
  end
endmodule
`default_nettype wire
